// >>> inc/rsw_pkg.sv
package rsw_pkg;
	// ****************************************
	// bus and register map
	// ****************************************
	localparam int SFR_AW = 8;
	localparam int SFR_DW = 8;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'hef;
	localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'hff;
	localparam logic [7:0] PAGE_RESET_CAUSE = 8'h00;
	localparam logic [7:0] RESET_CAUSE_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	// reset_cause_and_enable bit positions
	localparam int BIT_PIN = 0;
	localparam int BIT_POR = 1;
	localparam int BIT_MCD = 2;
	localparam int BIT_WDT = 3;
	localparam int BIT_SW = 4;
	localparam int BIT_CMP = 5;
	localparam int BIT_CNV = 6;

	// ****************************************
	// watchdog
	// ****************************************
	localparam int WD_WIDTH = 21;
	localparam int WD_IVL_W = 3;
	localparam int WD_EXP_BASE = 3;
	localparam logic [2:0] WD_INTERVAL_RESET = 3'h7;
	localparam int WD_IVL_GUARD_BIT = 7;
	localparam int WD_STATUS_BIT = 4;
	localparam logic [7:0] WD_CMD_KICK = 8'ha5;
	localparam logic [7:0] WD_CMD_DIS1 = 8'hde;
	localparam logic [7:0] WD_CMD_DIS2 = 8'had;
	localparam logic [7:0] WD_CMD_LOCK = 8'hff;
	localparam logic [2:0] WD_DIS_WINDOW = 3'h4;

	// ****************************************
	// timing, at a 40 MHz system clock
	// ****************************************
	localparam longint CLK_HZ = 40000000;
	localparam longint SUPPLY_TIMEOUT_MS = 100;
	localparam int SUPPLY_TIMEOUT_CYC = int'(CLK_HZ * SUPPLY_TIMEOUT_MS / 1000);
	localparam int PIN_STRETCH_CYC = 12;

	// ****************************************
	// reset-state values
	// ****************************************
	localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HOLD = 2'b01,
		ST_STRETCH = 2'b11,
		ST_SUPPLY = 2'b10
	} rsw_state_t;

	typedef enum logic [2:0] {
		C_POR = 3'h0,
		C_PIN = 3'h1,
		C_MCD = 3'h2,
		C_CMP = 3'h3,
		C_CNV = 3'h4,
		C_WDT = 3'h5,
		C_SW = 3'h6
	} rsw_cause_t;
endpackage

// >>> inc/rsw_wd_if.sv
`timescale 1ns/1ps
// ****************************************
// link between reset control and watchdog
// ****************************************
interface rsw_wd_if;
	logic sys_reset;
	logic ce;
	logic wr_stb;
	logic [7:0] wr_data;
	logic running;
	logic [rsw_pkg::WD_IVL_W-1:0] interval;
	logic overflow;
	modport ctrl (output sys_reset, ce, wr_stb, wr_data, input running, interval, overflow);
	modport wdog (input sys_reset, ce, wr_stb, wr_data, output running, interval, overflow);
endinterface

// >>> hw/rsw_watchdog.sv
`timescale 1ns/1ps
// ****************************************
// watchdog timer and its control commands
// ****************************************
module rsw_watchdog #(
	parameter int WIDTH = rsw_pkg::WD_WIDTH
) (
	input wire logic clk_in,
	rsw_wd_if.wdog wd
);
	import rsw_pkg::*;

	// the longest interval needs 2*(base+7) bits plus one
	if (WIDTH < 2 * (WD_EXP_BASE + 7) + 1) begin : g_bad_width
		$error("watchdog counter too narrow for the longest interval");
	end

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] limit;
	logic [2:0] dis_window;
	logic locked;
	logic kick;

	// timeout is four to the power of (3 + interval) clocks
	assign limit = WIDTH'(1) << (2 * (WD_EXP_BASE + int'(wd.interval)));
	assign kick = wd.wr_stb && wd.wr_data == WD_CMD_KICK;
	assign wd.overflow = wd.ce && wd.running && count == limit - WIDTH'(1);

	// disable window opens on the first half of the pair
	always_ff @(posedge clk_in) begin
		if (wd.sys_reset) begin
			dis_window <= 3'h0;
		end else if (wd.ce) begin
			if (wd.wr_stb && wd.wr_data == WD_CMD_DIS1) begin
				dis_window <= WD_DIS_WINDOW;
			end else if (dis_window != 3'h0) begin
				dis_window <= dis_window - 3'h1;
			end
		end
	end

	// enable, lock and interval; every reset restores the longest timeout
	always_ff @(posedge clk_in) begin
		if (wd.sys_reset) begin
			wd.running <= 1'b1;
			locked <= 1'b0;
			wd.interval <= WD_INTERVAL_RESET;
		end else if (wd.ce && wd.wr_stb) begin
			if (kick) begin
				wd.running <= 1'b1;
			end else if (wd.wr_data == WD_CMD_DIS2 && dis_window != 3'h0 && !locked) begin
				wd.running <= 1'b0;
			end
			if (wd.wr_data == WD_CMD_LOCK) begin
				locked <= 1'b1;
			end
			if (!wd.wr_data[WD_IVL_GUARD_BIT]) begin
				wd.interval <= wd.wr_data[WD_IVL_W-1:0];
			end
		end
	end

	// free count; wraps at the limit, where overflow fires once
	always_ff @(posedge clk_in) begin
		if (wd.sys_reset) begin
			count <= '0;
		end else if (wd.ce) begin
			if (kick || wd.overflow) begin
				count <= '0;
			end else if (wd.running) begin
				count <= count + WIDTH'(1);
			end
		end
	end
endmodule

// >>> hw/rsw_top.sv
`timescale 1ns/1ps
// Function
// - reset halts core, reinitialises registers, disables interrupts
// - reset leaves data memory untouched
// - port latches all ones during reset
// - exit clears counter, default clock, fetch zero
// - every reset enables watchdog, longest timeout
// - supply reset drives pin through timeout
// - monitor resets only when pin enables, selected
// - power-on sets its flag; others clear it
// - supply drop drives pin and resets core
// - pin reset stretched twelve clocks, sets flag
// - enabled clock loss resets, flags, pin untouched
// - enabled comparator below resets, flags, pin untouched
// - enabled convert-start low resets, blocks conversions
// - 21-bit watchdog overflow resets, pin untouched
// - kick command enables and restarts watchdog
// - disable pair within four clocks only
// - lock command blocks disable until reset
// - interval field sets timeout, guarded by bit7
// - watchdog control bit4 reads running status
// - software force bit resets, flags, pin untouched
// - watchdog cause bit read-only cause flag
// - pin force bit causes power-on style reset
module rsw_top #(
	parameter int SUPPLY_TIMEOUT = rsw_pkg::SUPPLY_TIMEOUT_CYC,
	parameter int STRETCH = rsw_pkg::PIN_STRETCH_CYC,
	parameter int WD_WIDTH = rsw_pkg::WD_WIDTH
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [rsw_pkg::SFR_AW-1:0] sfr_addr_in,
	input wire logic [rsw_pkg::SFR_AW-1:0] sfr_page_in,
	input wire logic [rsw_pkg::SFR_DW-1:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	output logic [rsw_pkg::SFR_DW-1:0] sfr_rdata_out,
	input wire logic supply_ok_in,
	input wire logic supply_monitor_enable_pin_in,
	input wire logic ext_reset_n_in,
	output logic ext_reset_out,
	output logic ext_reset_oe_out,
	input wire logic clock_missing_in,
	input wire logic compare_noninv_above_in,
	input wire logic conversion_start_input_in,
	output logic adc_convert_start_n_out,
	input wire logic osc_stable_in,
	output logic core_reset_out,
	output logic clock_default_out,
	output logic fetch_enable_out,
	output logic [15:0] fetch_addr_out,
	output logic port_latch_load_out,
	output logic [7:0] port_latch_value_out
);
	import rsw_pkg::*;

	// ****************************************
	// parameter checks
	// ****************************************
	localparam int CNT_W = $clog2(SUPPLY_TIMEOUT + 1);

	if (SUPPLY_TIMEOUT < 1) begin : g_bad_timeout
		$error("supply timeout must be at least one cycle");
	end
	if (STRETCH < 1 || STRETCH > SUPPLY_TIMEOUT) begin : g_bad_stretch
		$error("pin stretch must lie between one cycle and the supply timeout");
	end

	// ****************************************
	// declarations
	// ****************************************
	rsw_state_t state;
	rsw_cause_t cause;
	logic [CNT_W-1:0] cnt;
	logic [7:0] cause_flags;
	logic mon_sel;
	logic mcd_en;
	logic cmp_en;
	logic cnv_en;
	logic in_reset;
	logic wr_cause;
	logic wr_wd;
	logic rd_cause;
	logic rd_wd;
	logic supply_trip;
	logic pin_low;
	logic pin_force;
	logic sw_force;
	logic mcd_trip;
	logic cmp_trip;
	logic cnv_trip;
	logic stretch_done;
	logic supply_done;
	logic leave;
	logic [7:0] wd_read;

	rsw_wd_if wd_bus ();

	// ****************************************
	// register access
	// ****************************************
	// the core is halted in reset, so bus writes then are ignored
	assign in_reset = state != ST_RUN;

	// address decode; the cause register lives on one page only
	always_comb begin
		wr_cause = 1'b0;
		wr_wd = 1'b0;
		rd_cause = 1'b0;
		rd_wd = 1'b0;
		if (sfr_addr_in == ADDR_WATCHDOG_CTRL) begin
			wr_wd = sfr_wr_in && !in_reset;
			rd_wd = sfr_rd_in;
		end else if (sfr_addr_in == ADDR_RESET_CAUSE && sfr_page_in == PAGE_RESET_CAUSE) begin
			wr_cause = sfr_wr_in && !in_reset;
			rd_cause = sfr_rd_in;
		end
	end

	// force bits act as one-shot commands, never stored
	assign sw_force = ce_in && wr_cause && sfr_wdata_in[BIT_SW];
	assign pin_force = ce_in && wr_cause && sfr_wdata_in[BIT_PIN];

	// source enables; plain register bits, so any reset restores them
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || in_reset) begin
			mon_sel <= 1'b1;
			mcd_en <= 1'b0;
			cmp_en <= 1'b0;
			cnv_en <= 1'b0;
		end else if (ce_in && wr_cause) begin
			// selection only sticks while the monitor pin enables it
			if (supply_monitor_enable_pin_in) begin
				mon_sel <= sfr_wdata_in[BIT_POR];
			end
			mcd_en <= sfr_wdata_in[BIT_MCD];
			cmp_en <= sfr_wdata_in[BIT_CMP];
			cnv_en <= sfr_wdata_in[BIT_CNV];
		end
	end

	// watchdog byte: status in bit 4, interval in the low bits
	always_comb begin
		wd_read = READ_NONE;
		wd_read[WD_STATUS_BIT] = wd_bus.running;
		wd_read[WD_IVL_W-1:0] = wd_bus.interval;
	end

	// read data registered; unmapped addresses read zero
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sfr_rdata_out <= READ_NONE;
		end else if (ce_in) begin
			if (rd_cause) begin
				sfr_rdata_out <= cause_flags;
			end else if (rd_wd) begin
				sfr_rdata_out <= wd_read;
			end else begin
				sfr_rdata_out <= READ_NONE;
			end
		end
	end

	// ****************************************
	// reset sources
	// ****************************************
	// monitor acts only if strapped on and selected
	assign supply_trip = supply_monitor_enable_pin_in && mon_sel && !supply_ok_in;
	// while the block drives the pin itself, its own low is no cause
	assign pin_low = !ext_reset_n_in && !ext_reset_oe_out;
	// clock loss is timed by the outer one-shot; clock must return to act
	assign mcd_trip = mcd_en && clock_missing_in;
	assign cmp_trip = cmp_en && !compare_noninv_above_in;
	assign cnv_trip = cnv_en && !conversion_start_input_in;

	assign stretch_done = cnt == CNT_W'(STRETCH - 1);
	assign supply_done = cnt == CNT_W'(SUPPLY_TIMEOUT - 1);

	// the only ways back to running
	always_comb begin
		leave = 1'b0;
		case (state)
			ST_STRETCH: begin
				leave = !supply_trip && !pin_low && stretch_done;
			end
			ST_SUPPLY: begin
				leave = supply_ok_in && supply_done;
			end
			default: begin
				leave = 1'b0;
			end
		endcase
	end

	// ****************************************
	// reset sequencer
	// ****************************************
	// priority: supply, pin force, pin, clock loss, comparator,
	// convert start, watchdog, software
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state <= ST_SUPPLY;
			cause <= C_POR;
			cnt <= '0;
		end else if (ce_in) begin
			case (state)
				ST_RUN: begin
					cnt <= '0;
					if (supply_trip) begin
						state <= ST_SUPPLY;
						cause <= C_POR;
					end else if (pin_force) begin
						state <= ST_SUPPLY;
						cause <= C_PIN;
					end else if (pin_low) begin
						state <= ST_HOLD;
						cause <= C_PIN;
					end else if (mcd_trip) begin
						state <= ST_STRETCH;
						cause <= C_MCD;
					end else if (cmp_trip) begin
						state <= ST_STRETCH;
						cause <= C_CMP;
					end else if (cnv_trip) begin
						state <= ST_STRETCH;
						cause <= C_CNV;
					end else if (wd_bus.overflow) begin
						state <= ST_STRETCH;
						cause <= C_WDT;
					end else if (sw_force) begin
						state <= ST_STRETCH;
						cause <= C_SW;
					end
				end
				ST_HOLD: begin
					cnt <= '0;
					if (supply_trip) begin
						state <= ST_SUPPLY;
						cause <= C_POR;
					end else if (!pin_low) begin
						state <= ST_STRETCH;
					end
				end
				ST_STRETCH: begin
					if (supply_trip) begin
						state <= ST_SUPPLY;
						cause <= C_POR;
						cnt <= '0;
					end else if (pin_low) begin
						state <= ST_HOLD;
						cause <= C_PIN;
						cnt <= '0;
					end else if (leave) begin
						state <= ST_RUN;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				ST_SUPPLY: begin
					// a supply dip restarts the whole timeout
					if (!supply_ok_in) begin
						cnt <= '0;
					end else if (leave) begin
						state <= ST_RUN;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				default: begin
					state <= ST_SUPPLY;
				end
			endcase
		end
	end

	// ****************************************
	// cause flags
	// ****************************************
	// written on the way out so firmware sees one settled value;
	// after power-on the other flags just keep what they held
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cause_flags <= RESET_CAUSE_RESET;
		end else if (ce_in && leave) begin
			cause_flags <= RESET_CAUSE_RESET;
			case (cause)
				C_POR: begin
					cause_flags <= cause_flags;
					cause_flags[BIT_POR] <= 1'b1;
				end
				C_PIN: begin
					cause_flags[BIT_PIN] <= 1'b1;
				end
				C_MCD: begin
					cause_flags[BIT_MCD] <= 1'b1;
				end
				C_CMP: begin
					cause_flags[BIT_CMP] <= 1'b1;
				end
				C_CNV: begin
					cause_flags[BIT_CNV] <= 1'b1;
				end
				C_WDT: begin
					cause_flags[BIT_WDT] <= 1'b1;
				end
				C_SW: begin
					cause_flags[BIT_SW] <= 1'b1;
				end
				default: begin
					cause_flags <= RESET_CAUSE_RESET;
				end
			endcase
		end
	end

	// ****************************************
	// reset pin and core-side controls
	// ****************************************
	// only supply and forced-pin resets pull the pin low
	assign ext_reset_out = 1'b0;
	assign ext_reset_oe_out = state == ST_SUPPLY;

	// core halt, register init, interrupt and timer disable;
	// nothing here touches data memory, so its contents survive
	assign core_reset_out = in_reset;
	assign port_latch_load_out = in_reset;
	assign clock_default_out = in_reset;
	assign wd_bus.sys_reset = !rst_n_in || in_reset;
	assign wd_bus.ce = ce_in;
	assign wd_bus.wr_stb = wr_wd;
	assign wd_bus.wr_data = sfr_wdata_in;

	// values loaded while in reset; RAM has no clear path at all
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			port_latch_value_out <= PORT_LATCH_RESET;
			fetch_addr_out <= RESET_VECTOR;
		end else if (ce_in && in_reset) begin
			port_latch_value_out <= PORT_LATCH_RESET;
			fetch_addr_out <= RESET_VECTOR;
		end
	end

	// fetch waits for the oscillator once reset has ended
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			fetch_enable_out <= 1'b0;
		end else if (ce_in) begin
			if (in_reset) begin
				fetch_enable_out <= 1'b0;
			end else if (osc_stable_in) begin
				fetch_enable_out <= 1'b1;
			end
		end
	end

	// convert start is swallowed while it serves as a reset source
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			adc_convert_start_n_out <= 1'b1;
		end else if (ce_in) begin
			adc_convert_start_n_out <= cnv_en ? 1'b1 : conversion_start_input_in;
		end
	end

	// ****************************************
	// watchdog
	// ****************************************
	rsw_watchdog #(
		.WIDTH(WD_WIDTH)
	) u_watchdog (
		.clk_in(clk_in),
		.wd(wd_bus.wdog)
	);
endmodule

// >>> verification/rsw_top_checker.sv
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module rsw_top_checker import rsw_pkg::*; #(
	parameter int SUPPLY_TIMEOUT = 50
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [SFR_AW-1:0] sfr_addr_in,
	input wire logic [SFR_AW-1:0] sfr_page_in,
	input wire logic [SFR_DW-1:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [SFR_DW-1:0] sfr_rdata_out,
	input wire logic supply_ok_in,
	input wire logic ext_reset_n_in,
	input wire logic ext_reset_oe_out,
	input wire logic adc_convert_start_n_out,
	input wire logic core_reset_out,
	input wire logic clock_default_out,
	input wire logic port_latch_load_out,
	input wire logic [7:0] port_latch_value_out
);
	int hold_cnt;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// unbroken supply-ok cycles while the pin is held low; a dip restarts it
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !ext_reset_oe_out || !supply_ok_in) begin
			hold_cnt <= 0;
		end else if (supply_ok_in && ce_in) begin
			hold_cnt <= hold_cnt + 1;
		end
	end
	// lower and upper bound: the stretch may run up to two cycles longer
	sequence s_stretch;
		core_reset_out [*8] ##5 core_reset_out ##[1:3] !core_reset_out;
	endsequence
	sequence s_cause_wr;
		sfr_wr_in && ce_in && sfr_addr_in == ADDR_RESET_CAUSE
			&& sfr_page_in == PAGE_RESET_CAUSE && !core_reset_out;
	endsequence
	property p_latch;
		port_latch_load_out == core_reset_out && port_latch_value_out == PORT_LATCH_RESET
			&& clock_default_out == core_reset_out;
	endproperty
	property p_pin_entry;
		ce_in && !ext_reset_n_in && !ext_reset_oe_out && !core_reset_out |=> core_reset_out;
	endproperty
	property p_stretch;
		$rose(ext_reset_n_in) && !$past(ext_reset_oe_out) && core_reset_out |-> s_stretch;
	endproperty
	property p_quiet;
		$rose(core_reset_out) && $past(supply_ok_in) && !$past(sfr_wr_in) |-> !ext_reset_oe_out;
	endproperty
	property p_sw;
		s_cause_wr ##0 (sfr_wdata_in[BIT_SW] && !sfr_wdata_in[BIT_PIN])
			|=> core_reset_out && !ext_reset_oe_out;
	endproperty
	property p_conv;
		s_cause_wr ##0 sfr_wdata_in[BIT_CNV] |=> ##2 adc_convert_start_n_out;
	endproperty
	property p_trip;
		!supply_ok_in && ext_reset_oe_out |=> ext_reset_oe_out && core_reset_out;
	endproperty
	property p_exit;
		$fell(ext_reset_oe_out) |-> !core_reset_out
			&& hold_cnt inside {[SUPPLY_TIMEOUT - 1:SUPPLY_TIMEOUT]};
	endproperty
	property p_wd_fmt;
		sfr_rd_in && ce_in && sfr_addr_in == ADDR_WATCHDOG_CTRL && !core_reset_out
			|=> sfr_rdata_out[7:5] == 3'h0 && !sfr_rdata_out[3];
	endproperty
	a_latch: assert property (p_latch) else $error("latch or clock select off");
	a_pin_entry: assert property (p_pin_entry) else $error("pin low ignored");
	a_stretch: assert property (p_stretch) else $error("pin stretch short");
	a_quiet: assert property (p_quiet) else $error("pin driven by core reset");
	a_sw: assert property (p_sw) else $error("software force failed");
	a_conv: assert property (p_conv) else $error("convert start not blocked");
	a_trip: assert property (p_trip) else $error("supply hold dropped");
	a_exit: assert property (p_exit) else $error("supply timeout wrong");
	a_wd_fmt: assert property (p_wd_fmt) else $error("watchdog read format");
endmodule

bind rsw_top rsw_top_checker #(.SUPPLY_TIMEOUT(SUPPLY_TIMEOUT)) u_rsw_top_checker (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .sfr_addr_in(sfr_addr_in),
	.sfr_page_in(sfr_page_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
	.sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .supply_ok_in(supply_ok_in),
	.ext_reset_n_in(ext_reset_n_in), .ext_reset_oe_out(ext_reset_oe_out),
	.adc_convert_start_n_out(adc_convert_start_n_out), .core_reset_out(core_reset_out),
	.clock_default_out(clock_default_out), .port_latch_load_out(port_latch_load_out),
	.port_latch_value_out(port_latch_value_out));

// >>> verification/rsw_pin_model.sv
`timescale 1ns/1ps
// ********************
// reset pin on the board
// ********************
module rsw_pin_model (
	input wire logic press_in,
	input wire logic oe_in,
	output logic pin_n_out
);
	// open drain with pull-up: either party pulling low wins
	assign pin_n_out = !(press_in || oe_in);
endmodule

// >>> verification/test_rsw_top.sv
`timescale 1ns/1ps
// ********************
// self-checking bench
// ********************
module test_rsw_top;
	import rsw_pkg::*;
	localparam int ST = 50;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] page = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic sup = 1'b1;
	logic strap = 1'b1;
	logic press = 1'b0;
	logic miss = 1'b0;
	logic cmp = 1'b1;
	logic cnv_n = 1'b1;
	logic ce = 1'b1;
	logic osc = 1'b0;
	logic fetch_en;
	logic ext_rst;
	logic [15:0] fetch_addr;
	logic pin_n;
	logic oe;
	logic core_rst;
	logic adc_n;
	logic [7:0] rdata;
	logic [2:0] ivl;
	logic [7:0] exp_q[$];
	int fail_count = 0;
	int checked = 0;
	rsw_top #(.SUPPLY_TIMEOUT(ST)) u_rsw_top (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .sfr_addr_in(addr),
		.sfr_page_in(page), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
		.sfr_rdata_out(rdata), .supply_ok_in(sup), .supply_monitor_enable_pin_in(strap),
		.ext_reset_n_in(pin_n), .ext_reset_out(ext_rst), .ext_reset_oe_out(oe),
		.clock_missing_in(miss), .compare_noninv_above_in(cmp),
		.conversion_start_input_in(cnv_n), .adc_convert_start_n_out(adc_n),
		.osc_stable_in(osc), .core_reset_out(core_rst), .clock_default_out(),
		.fetch_enable_out(fetch_en), .fetch_addr_out(fetch_addr), .port_latch_load_out(),
		.port_latch_value_out());
	rsw_pin_model u_rsw_pin_model (.press_in(press), .oe_in(oe), .pin_n_out(pin_n));
	initial forever #12.5 clk_in = ~clk_in;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// writes land two cycles apart, inside the disable window
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr = a;
		page = PAGE_RESET_CAUSE;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_in);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
		@(negedge clk_in);
		addr = a;
		page = p;
		rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk_in);
		rd = 1'b0;
	endtask
	task automatic wait_rst(input logic v);
		int n;
		n = 0;
		while (core_rst !== v && n < 4000) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 4000) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic see_cause(input logic [7:0] e);
		wait_rst(1'b1);
		wait_rst(1'b0);
		rd_reg(ADDR_RESET_CAUSE, PAGE_RESET_CAUSE, e);
	endtask
	task automatic idle_ok();
		repeat (4) @(negedge clk_in);
		check({7'h00, core_rst}, 8'h00);
	endtask
	// read data settles one cycle after the read edge
	always @(posedge clk_in) rd_d <= rd;
	always @(negedge clk_in) begin
		if (rd_d && exp_q.size() > 0) begin
			check(rdata, exp_q.pop_front());
		end
	end
	initial begin
		void'($urandom(55));
		repeat (16) @(negedge clk_in);
		rst_n_in = 1'b1;
		wait_rst(1'b0);
		// fetch must wait for the oscillator even after reset has ended
		check({7'h00, fetch_en}, 8'h00);
		osc = 1'b1;
		@(negedge clk_in);
		check({6'h00, fetch_en, |fetch_addr}, 8'h02);
		rd_reg(ADDR_RESET_CAUSE, 8'h00, 8'h02);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h05, 8'h17);
		rd_reg(ADDR_RESET_CAUSE, 8'h01, READ_NONE);
		rd_reg(8'h10, 8'h00, READ_NONE);
		// disable pair issued back to back
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS1);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS2);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, 8'h07);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_KICK);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, 8'h17);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS1);
		repeat (5) @(negedge clk_in);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS2);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, 8'h17);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_LOCK);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS1);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS2);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, 8'h17);
		ivl = 3'($urandom_range(1, 6));
		wr_reg(ADDR_WATCHDOG_CTRL, {5'h00, ivl});
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, {5'h02, ivl});
		wr_reg(ADDR_WATCHDOG_CTRL, 8'h80);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, {5'h02, ivl});
		// shortest interval is 64 clocks: quiet at 55, reset soon after
		wr_reg(ADDR_WATCHDOG_CTRL, 8'h00);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_KICK);
		repeat (55) @(negedge clk_in);
		check({7'h00, core_rst}, 8'h00);
		see_cause(8'h08);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS1);
		wr_reg(ADDR_WATCHDOG_CTRL, WD_CMD_DIS2);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, 8'h07);
		press = 1'b1;
		repeat (5) @(negedge clk_in);
		check({7'h00, core_rst}, 8'h01);
		check({6'h00, fetch_en, core_rst}, 8'h01);
		press = 1'b0;
		see_cause(8'h01);
		wr_reg(ADDR_RESET_CAUSE, 8'h12);
		see_cause(8'h10);
		// sources stay quiet until their enable is written
		cmp = 1'b0;
		idle_ok();
		cmp = 1'b1;
		wr_reg(ADDR_RESET_CAUSE, 8'h22);
		// clock enable low freezes the sequencer, trip waits for it
		ce = 1'b0;
		cmp = 1'b0;
		idle_ok();
		ce = 1'b1;
		see_cause(8'h20);
		cmp = 1'b1;
		cnv_n = 1'b0;
		idle_ok();
		check({7'h00, adc_n}, 8'h00);
		cnv_n = 1'b1;
		wr_reg(ADDR_RESET_CAUSE, 8'h42);
		repeat (3) @(negedge clk_in);
		cnv_n = 1'b0;
		see_cause(8'h40);
		cnv_n = 1'b1;
		miss = 1'b1;
		idle_ok();
		miss = 1'b0;
		wr_reg(ADDR_RESET_CAUSE, 8'h06);
		miss = 1'b1;
		see_cause(8'h04);
		miss = 1'b0;
		wr_reg(ADDR_RESET_CAUSE, 8'h00);
		sup = 1'b0;
		idle_ok();
		sup = 1'b1;
		strap = 1'b0;
		wr_reg(ADDR_RESET_CAUSE, 8'h02);
		sup = 1'b0;
		idle_ok();
		sup = 1'b1;
		strap = 1'b1;
		wr_reg(ADDR_RESET_CAUSE, 8'h01);
		repeat (2) @(negedge clk_in);
		check({7'h00, oe}, 8'h01);
		check({6'h00, ext_rst, oe}, 8'h01);
		see_cause(8'h01);
		sup = 1'b0;
		repeat (5) @(negedge clk_in);
		check({6'h00, oe, core_rst}, 8'h03);
		sup = 1'b1;
		see_cause(8'h03);
		rst_n_in = 1'b0;
		repeat (3) @(negedge clk_in);
		check(rdata, READ_NONE);
		check({6'h00, oe, core_rst}, 8'h03);
		rst_n_in = 1'b1;
		wait_rst(1'b0);
		rd_reg(ADDR_RESET_CAUSE, 8'h00, 8'h02);
		rd_reg(ADDR_WATCHDOG_CTRL, 8'h00, 8'h17);
		// let the last read be compared; an unanswered note is a miss
		@(negedge clk_in);
		check(8'(exp_q.size()), 8'h00);
		report_and_stop();
	end
endmodule
